//--- core/frame_offset_measurement.sv
// Purpose: Frame offset measurement with AXI4-Lite register access
// Assumes: Master clock, frame pulse and evaluation input synchronous to I_CLK
// Notes:   Phase bit is the master clock level at the sampled edge
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Function
// - Done flag bit 12 set when evaluation finishes
// - Start bit falling clears done flag
// - Falling edge default, rising edge in GCI
// - Bit 11 records clock phase at edge
// - Bits 10-0 hold unsigned measured offset
// - Start bit falling clears offset bits
// - Start rise begins; done rise stops measurement
module frame_offset_measurement (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  // Frame timing and evaluation input
  input  wire logic        I_MCLK,
  input  wire logic        I_FRAME_START,
  input  wire logic        I_FRAME_EVAL_INPUT,
  input  wire logic        I_GCI_MODE,
  // AXI4-Lite write address and data
  input  wire logic        I_AWVALID,
  input  wire logic [31:0] I_AWADDR,
  output logic             O_AWREADY,
  input  wire logic        I_WVALID,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  output logic             O_WREADY,
  // AXI4-Lite write response
  output logic             O_BVALID,
  output logic [1:0]       O_BRESP,
  input  wire logic        I_BREADY,
  // AXI4-Lite read
  input  wire logic        I_ARVALID,
  input  wire logic [31:0] I_ARADDR,
  output logic             O_ARREADY,
  output logic             O_RVALID,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  input  wire logic        I_RREADY,
  // Interrupt
  output logic             O_IRQ
);
  import fom_pkg::*;

  // ==========================================================================
  // Register state
  logic [MODE_W-1:0] interface_mode_register_q;
  logic [15:0]       frame_offset_adjust_stream_group0_q;
  far_t              frame_alignment_result_q;
  logic              irq_status_q;
  logic              irq_mask_q;
  logic              start_prev_q;

  // ==========================================================================
  // Measurement state
  meas_state_t      state_q;
  meas_state_t      state_d;
  logic [OFS_W-1:0] count_q;
  logic [OFS_W-1:0] count_d;
  logic             eval_in_q;
  logic             mclk_q;

  wire start_now  = interface_mode_register_q[START_POS];
  wire start_rise = start_now & ~start_prev_q;
  wire start_fall = ~start_now & start_prev_q;
  wire mclk_rise  = I_MCLK & ~mclk_q;
  // Edge choice follows the framing mode
  wire eval_edge  = I_GCI_MODE ? (I_FRAME_EVAL_INPUT & ~eval_in_q)
                               : (~I_FRAME_EVAL_INPUT & eval_in_q);
  wire capture    = (state_q == ST_COUNT) & eval_edge & ~start_fall;

  // ==========================================================================
  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_rise) begin
          state_d = ST_ARM;
        end
      end
      ST_ARM: begin
        if (I_FRAME_START) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (capture) begin
          state_d = ST_DONE;
        end
      end
      default: begin
        state_d = ST_DONE;
      end
    endcase
    // Dropping the start bit abandons any evaluation
    if (start_fall) begin
      state_d = ST_IDLE;
    end
  end

  // Restart at each frame boundary, hold at the top rather than wrap
  assign count_d = (state_q != ST_COUNT || I_FRAME_START) ? OFS_RST
                 : (mclk_rise && count_q != OFS_MAX)      ? count_q + 11'h001
                 : count_q;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state_q   <= ST_IDLE;
      count_q   <= OFS_RST;
      eval_in_q <= 1'b1;
      mclk_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      count_q   <= count_d;
      eval_in_q <= I_FRAME_EVAL_INPUT;
      mclk_q    <= I_MCLK;
    end
  end

  // ==========================================================================
  // Result register
  far_t far_d;
  always_comb begin
    far_d = frame_alignment_result_q;
    if (start_fall) begin
      far_d.eval_done_flag     = 1'b0;
      far_d.offset_count_field = OFS_RST;
    end else if (capture) begin
      far_d.eval_done_flag     = 1'b1;
      far_d.sample_phase_bit   = I_MCLK;
      far_d.offset_count_field = count_q;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      frame_alignment_result_q <= FAR_RST;
    end else begin
      frame_alignment_result_q <= far_d;
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  logic        aw_full_q;
  logic        w_full_q;
  logic [9:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  wire aw_take  = I_AWVALID & O_AWREADY;
  wire w_take   = I_WVALID & O_WREADY;
  wire wr_fire  = aw_full_q & w_full_q & ~O_BVALID;
  wire aw_full_d = (aw_full_q | aw_take) & ~wr_fire;
  wire w_full_d  = (w_full_q | w_take) & ~wr_fire;
  wire wr_mode = wr_fire && (waddr_q == ADDR_MODE);
  wire wr_far  = wr_fire && (waddr_q == ADDR_FAR);
  wire wr_adj0 = wr_fire && (waddr_q == ADDR_ADJ0);
  wire wr_ist  = wr_fire && (waddr_q == ADDR_IST);
  wire wr_imsk = wr_fire && (waddr_q == ADDR_IMSK);
  wire wr_hit  = wr_mode | wr_far | wr_adj0 | wr_ist | wr_imsk;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  wire [15:0] mode_wr = merge16({6'h00, interface_mode_register_q}, wdata_q, wstrb_q);
  wire [15:0] adj0_wr = merge16(frame_offset_adjust_stream_group0_q, wdata_q, wstrb_q);
  // Set beats clear when both land in one cycle
  wire ist_d = capture | (irq_status_q & ~(wr_ist & wstrb_q[0] & wdata_q[0]));

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      waddr_q   <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      O_AWREADY <= ~aw_full_d;
      O_WREADY  <= ~w_full_d;
      if (aw_take) begin
        waddr_q <= {I_AWADDR[9:2], 2'b00};
      end
      if (w_take) begin
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (wr_fire) begin
        O_BVALID <= 1'b1;
        O_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Reserved upper bits of the result are not stored, so they stay zero
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      interface_mode_register_q           <= MODE_RST;
      frame_offset_adjust_stream_group0_q <= ADJ0_RST;
      irq_status_q                        <= 1'b0;
      irq_mask_q                          <= 1'b0;
      start_prev_q                        <= 1'b0;
      O_IRQ                               <= 1'b0;
    end else begin
      if (wr_mode) begin
        interface_mode_register_q <= mode_wr[MODE_W-1:0];
      end
      if (wr_adj0) begin
        frame_offset_adjust_stream_group0_q <= adj0_wr;
      end
      if (wr_imsk && wstrb_q[0]) begin
        irq_mask_q <= wdata_q[0];
      end
      irq_status_q <= ist_d;
      start_prev_q <= start_now;
      O_IRQ        <= ist_d & ((wr_imsk && wstrb_q[0]) ? wdata_q[0] : irq_mask_q);
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  wire [9:0]  raddr    = {I_ARADDR[9:2], 2'b00};
  wire        rd_mode  = (raddr == ADDR_MODE);
  wire        rd_far   = (raddr == ADDR_FAR);
  wire        rd_adj0  = (raddr == ADDR_ADJ0);
  wire        rd_ist   = (raddr == ADDR_IST);
  wire        rd_imsk  = (raddr == ADDR_IMSK);
  wire        rd_hit   = rd_mode | rd_far | rd_adj0 | rd_ist | rd_imsk;
  wire [31:0] rd_mux   = rd_mode ? {22'h000000, interface_mode_register_q}
                       : rd_far  ? {16'h0000, FAR_RSVD, frame_alignment_result_q}
                       : rd_adj0 ? {16'h0000, frame_offset_adjust_stream_group0_q}
                       : rd_ist  ? {31'h00000000, irq_status_q}
                       : rd_imsk ? {31'h00000000, irq_mask_q}
                       : 32'h0000_0000;
  wire        ar_take  = I_ARVALID & O_ARREADY;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= RESP_OKAY;
    end else if (ar_take) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RDATA   <= rd_mux;
      O_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (O_RVALID) begin
      O_RVALID  <= ~I_RREADY;
      O_ARREADY <= I_RREADY;
    end else begin
      O_ARREADY <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  property p_done_on_capture;
    capture |=> frame_alignment_result_q.eval_done_flag && state_q == ST_DONE;
  endproperty
  a_done_on_capture: assert property (p_done_on_capture)
    else $error("done flag not set after capture");

  property p_done_clear;
    start_fall |=> !frame_alignment_result_q.eval_done_flag;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done flag kept after start fell");

  property p_edge_mode;
    (state_q == ST_COUNT && !start_fall && (I_GCI_MODE ? (!I_FRAME_EVAL_INPUT && eval_in_q)
       : (I_FRAME_EVAL_INPUT && !eval_in_q))) |=> state_q == ST_COUNT;
  endproperty
  a_edge_mode: assert property (p_edge_mode)
    else $error("wrong edge of evaluation input captured");

  property p_phase;
    capture |=> frame_alignment_result_q.sample_phase_bit == $past(I_MCLK);
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase bit does not match clock level");

  property p_offset_value;
    capture |=> frame_alignment_result_q.offset_count_field == $past(count_q);
  endproperty
  a_offset_value: assert property (p_offset_value)
    else $error("offset field does not match count");

  property p_offset_clear;
    start_fall |=> frame_alignment_result_q.offset_count_field == OFS_RST;
  endproperty
  a_offset_clear: assert property (p_offset_clear)
    else $error("offset not cleared after start fell");

  property p_start_stop;
    (state_q == ST_DONE && !start_fall) |=> $stable(frame_alignment_result_q);
  endproperty
  a_start_stop: assert property (p_start_stop)
    else $error("result changed after completion");

  property p_count;
    (state_q == ST_COUNT && !I_FRAME_START && mclk_rise && count_q != OFS_MAX)
      |=> count_q == $past(count_q) + 11'h001;
  endproperty
  a_count: assert property (p_count)
    else $error("offset count missed a master clock edge");

  property p_arm_on_rise;
    (state_q == ST_IDLE && start_rise) |=> state_q == ST_ARM;
  endproperty
  a_arm_on_rise: assert property (p_arm_on_rise)
    else $error("start rise did not arm the evaluation");

  property p_frame_restart;
    ((state_q == ST_ARM || state_q == ST_COUNT) && I_FRAME_START && !start_fall && !capture)
      |=> state_q == ST_COUNT && count_q == OFS_RST;
  endproperty
  a_frame_restart: assert property (p_frame_restart)
    else $error("frame boundary did not restart the count");

  property p_status_set;
    capture |=> irq_status_q;
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("completion did not set the status bit");

endmodule // frame_offset_measurement

//--- core/fom_pkg.sv
// Purpose: Constants and types for the frame offset measurement block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Register offsets are word indices; byte address is four times index
package fom_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  localparam logic [7:0] IDX_MODE = 8'h01;
  localparam logic [7:0] IDX_FAR  = 8'h02;
  localparam logic [7:0] IDX_ADJ0 = 8'h03;
  localparam logic [7:0] IDX_IST  = 8'h08;
  localparam logic [7:0] IDX_IMSK = 8'h09;
  localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [9:0] ADDR_FAR  = {IDX_FAR, 2'b00};
  localparam logic [9:0] ADDR_ADJ0 = {IDX_ADJ0, 2'b00};
  localparam logic [9:0] ADDR_IST  = {IDX_IST, 2'b00};
  localparam logic [9:0] ADDR_IMSK = {IDX_IMSK, 2'b00};

  // ==========================================================================
  // Fields and reset values
  localparam int          MODE_W        = 10;
  localparam int          START_POS     = 2;
  localparam int          OFS_W         = 11;
  localparam logic [9:0]  MODE_RST      = 10'h000;
  localparam logic [15:0] ADJ0_RST      = 16'h0000;
  localparam logic [10:0] OFS_RST       = 11'h000;
  localparam logic [10:0] OFS_MAX       = 11'h7FF;
  localparam logic [2:0]  FAR_RSVD      = 3'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARM   = 2'b01,
    ST_COUNT = 2'b10,
    ST_DONE  = 2'b11
  } meas_state_t;

  typedef struct packed {
    logic              eval_done_flag;
    logic              sample_phase_bit;
    logic [OFS_W-1:0]  offset_count_field;
  } far_t;

  localparam far_t FAR_RST = '{eval_done_flag: 1'b0, sample_phase_bit: 1'b0,
                               offset_count_field: OFS_RST};

endpackage

//--- bench/testbench.sv
// Purpose: Self-checking bench for the frame offset measurement block
// Assumes: Bus answers come on the design's own timing, never counted
// Notes:   Response readies held high; strobes full except one lane test
`timescale 1ns/100ps
module testbench;
  import fom_pkg::*;
  // ==========================================================================
  // Signals
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic        mclk      = 1'b0;
  logic        fs        = 1'b0;
  logic        ev_in     = 1'b1;
  logic [3:0]  ws        = 4'hF;
  logic        gci       = 1'b0;
  logic        awv       = 1'b0;
  logic [31:0] awa       = 32'h0;
  logic        wv        = 1'b0;
  logic [31:0] wd        = 32'h0;
  logic        arv       = 1'b0;
  logic [31:0] ara       = 32'h0;
  logic        awr, wrd, bv, arr, rv, irq;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  logic        ph_last   = 1'b0;
  // Rows: gci, phase, mask, mclk rises, expected offset
  logic [25:0] rows [5]  = '{{1'b0, 1'b0, 1'b1, 12'd5, 11'd5},
                             {1'b0, 1'b1, 1'b0, 12'd37, 11'd38},
                             {1'b1, 1'b0, 1'b1, 12'd0, 11'd0},
                             {1'b1, 1'b1, 1'b1, 12'd12, 11'd13},
                             {1'b0, 1'b0, 1'b1, 12'd2050, 11'h7FF}};
  logic [9:0]  regs [5]  = '{ADDR_MODE, ADDR_FAR, ADDR_ADJ0, ADDR_IST, ADDR_IMSK};

  always #4 clk = ~clk;

  frame_offset_measurement uut (
    .I_CLK(clk), .I_SYS_RST(rst), .I_MCLK(mclk), .I_FRAME_START(fs),
    .I_FRAME_EVAL_INPUT(ev_in), .I_GCI_MODE(gci), .I_AWVALID(awv), .I_AWADDR(awa),
    .O_AWREADY(awr), .I_WVALID(wv), .I_WDATA(wd), .I_WSTRB(ws), .O_WREADY(wrd),
    .O_BVALID(bv), .O_BRESP(br), .I_BREADY(1'b1), .I_ARVALID(arv), .I_ARADDR(ara),
    .O_ARREADY(arr), .O_RVALID(rv), .O_RDATA(rdat), .O_RRESP(rr), .I_RREADY(1'b1),
    .O_IRQ(irq));

  // ==========================================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
    awv <= 1'b1;
    awa <= {22'h0, a};
    wv  <= 1'b1;
    wd  <= d;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    chk({30'h0, br}, {30'h0, er});
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    arv <= 1'b1;
    ara <= {22'h0, a};
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    chk(rdat, ed);
    chk({30'h0, rr}, {30'h0, er});
  endtask

  task automatic pulse_frame();
    fs <= 1'b1;
    tick(1);
    fs <= 1'b0;
    tick(1);
  endtask

  // A capture-direction edge is offered while armed in rows whose gci differs from the previous row's, and a wrong-direction edge during counting
  task automatic meas(input logic [25:0] r);
    gci <= r[25];
    wr(ADDR_IMSK, {31'h0, r[23]}, RESP_OKAY);
    wr(ADDR_MODE, 32'h4, RESP_OKAY);
    ev_in <= r[25];
    tick(2);
    pulse_frame();
    ev_in <= ~r[25];
    tick(1);
    repeat (r[22:11]) begin
      mclk <= 1'b1;
      tick(1);
      mclk <= 1'b0;
      tick(1);
    end
    mclk <= r[24];
    tick(1);
    ev_in <= r[25];
    tick(3);
    rd(ADDR_FAR, {19'h0, 1'b1, r[24], r[10:0]}, RESP_OKAY);
    chk({31'h0, irq}, {31'h0, r[23]});
    rd(ADDR_IST, 32'h1, RESP_OKAY);
    wr(ADDR_IST, 32'h1, RESP_OKAY);
    rd(ADDR_IST, 32'h0, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_MODE, 32'h0, RESP_OKAY);
    rd(ADDR_FAR, {20'h0, r[24], 11'h0}, RESP_OKAY);
    ph_last = r[24];
    // Start held low across a whole frame before the next row
    pulse_frame();
    pulse_frame();
  endtask

  // ==========================================================================
  // Hang guard, generous beyond the saturating row
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      $display("CHECK FAILED %0t timeout", $time);
      complete_run();
    end
  end

  // ==========================================================================
  // Sequence
  initial begin
    tick(2);
    rst <= 1'b0;
    tick(1);
    foreach (rows[i]) meas(rows[i]);
    // Abort mid-count
    wr(ADDR_MODE, 32'h4, RESP_OKAY);
    ev_in <= 1'b1;
    tick(2);
    pulse_frame();
    mclk <= 1'b1;
    tick(1);
    mclk <= 1'b0;
    wr(ADDR_MODE, 32'h0, RESP_OKAY);
    ev_in <= 1'b0;
    tick(3);
    rd(ADDR_FAR, {20'h0, ph_last, 11'h0}, RESP_OKAY);
    rd(ADDR_IST, 32'h0, RESP_OKAY);
    // Storage widths, read-only result, unmapped place
    wr(ADDR_ADJ0, 32'hFFFFA5C3, RESP_OKAY);
    rd(ADDR_ADJ0, 32'h0000A5C3, RESP_OKAY);
    // Only the low byte lane enabled
    ws <= 4'h1;
    wr(ADDR_ADJ0, 32'h0000_1234, RESP_OKAY);
    ws <= 4'hF;
    rd(ADDR_ADJ0, 32'h0000A534, RESP_OKAY);
    wr(ADDR_MODE, 32'hFFFFFFFB, RESP_OKAY);
    rd(ADDR_MODE, 32'h000003FB, RESP_OKAY);
    wr(ADDR_FAR, 32'h0, RESP_OKAY);
    rd(ADDR_FAR, {20'h0, ph_last, 11'h0}, RESP_OKAY);
    wr(10'h3FC, 32'h1, RESP_SLVERR);
    rd(10'h3FC, 32'h0, RESP_SLVERR);
    // Second reset clears everything
    wr(ADDR_IMSK, 32'h1, RESP_OKAY);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    foreach (regs[i]) rd(regs[i], 32'h0, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    complete_run();
  end
endmodule // testbench
